// file: common/uart_ctl_pkg.sv
package uart_ctl_pkg;
	typedef logic [4:0] reg_addr_t;
	localparam reg_addr_t ADDR_DIVISOR_LOW = 5'h00;
	localparam reg_addr_t ADDR_DIVISOR_HIGH = 5'h01;
	localparam reg_addr_t ADDR_DIVISOR_FRAC = 5'h02;
	localparam reg_addr_t ADDR_IRQ_ENABLE = 5'h03;
	localparam reg_addr_t ADDR_FIFO_CONTROL = 5'h04;
	localparam reg_addr_t ADDR_MODEM_CONTROL = 5'h05;
	localparam reg_addr_t ADDR_FLOW_THRESHOLD = 5'h06;
	localparam reg_addr_t ADDR_FIFO_TRIGGER = 5'h07;
	localparam reg_addr_t ADDR_SCRATCH = 5'h08;
	localparam reg_addr_t ADDR_GPIO_DIRECTION = 5'h09;
	localparam reg_addr_t ADDR_GPIO_LEVEL = 5'h0A;
	localparam reg_addr_t ADDR_GPIO_IRQ_ENABLE = 5'h0B;
	localparam reg_addr_t ADDR_GPIO_CONTROL = 5'h0C;
	localparam reg_addr_t ADDR_EXTRA_FEATURES = 5'h0D;
	localparam reg_addr_t ADDR_ENHANCED_SELECT = 5'h0E;
	localparam reg_addr_t ADDR_RESUME_FIRST = 5'h0F;
	localparam reg_addr_t ADDR_RESUME_SECOND = 5'h10;
	localparam reg_addr_t ADDR_PAUSE_FIRST = 5'h11;
	localparam reg_addr_t ADDR_PAUSE_SECOND = 5'h12;
	localparam int unsigned CTL_LATCH_BIT = 0;
	localparam int unsigned CTL_MODEM_SEL_BIT = 1;
	localparam int unsigned CTL_SOFT_RESET_BIT = 3;
	localparam int unsigned EXTRA_FEATURES_CONTROL_NINE_BIT = 0;
	localparam int unsigned EXTRA_FEATURES_CONTROL_RX_DIS_BIT = 1;
	localparam int unsigned EXTRA_FEATURES_CONTROL_TX_DIS_BIT = 2;
	localparam int unsigned EXTRA_FEATURES_CONTROL_RS485_EN_BIT = 4;
	localparam int unsigned EXTRA_FEATURES_CONTROL_RS485_POL_BIT = 5;
	localparam int unsigned EXTRA_FEATURES_CONTROL_IRDA_BIT = 7;
	localparam int unsigned FRAC_8X_BIT = 4;
	localparam int unsigned FRAC_4X_BIT = 5;
	localparam int unsigned EFR_ENH_BIT = 4;
	localparam int unsigned EFR_AUTO_RTS_BIT = 6;
	localparam int unsigned MCR_DTR_BIT = 0;
	localparam int unsigned MCR_RTS_BIT = 1;
	localparam logic [7:0] CTL_RW_MASK = 8'h03;
	localparam logic [7:0] EXTRA_FEATURES_CONTROL_RW_MASK = 8'hB7;
	localparam logic [7:0] FRAC_RW_MASK = 8'h3F;
	localparam logic [7:0] IER_ENH_MASK = 8'hF0;
	localparam logic [7:0] FCR_ENH_MASK = 8'h30;
	localparam logic [7:0] MCR_ENH_MASK = 8'hE4;
	localparam logic [7:0] ALL_ENH_MASK = 8'hFF;
	localparam logic [3:0] UPPER_ON = 4'hF;
	localparam logic [3:0] UPPER_OFF = 4'h0;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DIV_LOW = 8'h01;
	localparam logic [7:0] RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] RST_SCRATCH = 8'hFF;
	localparam logic [7:0] RST_FLOW_CHAR = 8'h00;
	localparam logic [7:0] RST_THRESHOLD = 8'h0F;
	localparam logic [2:0] MODEM_IDLE_N = 3'h7;
	localparam logic [1:0] FLOW_NONE = 2'b00;
	localparam logic [1:0] FLOW_FIRST = 2'b10;
	localparam logic [1:0] FLOW_SECOND = 2'b01;
	localparam logic [1:0] FLOW_BOTH = 2'b11;
	localparam logic [1:0] COUNT_NONE = 2'h0;
	localparam logic [1:0] COUNT_ONE = 2'h1;
	localparam logic [1:0] COUNT_TWO = 2'h2;
	typedef enum logic [2:0] {
		OVS_16X = 3'b001,
		OVS_8X = 3'b010,
		OVS_4X = 3'b100
	} oversample_t;
	typedef enum logic [2:0] {
		MATCH_IDLE = 3'b001,
		MATCH_RESUME = 3'b010,
		MATCH_PAUSE = 3'b100
	} match_state_t;
	typedef struct packed {
		logic [19:0] divisor;
		oversample_t oversample;
		logic irda_fast;
		logic nine_bit;
		logic tx_allow;
		logic rx_allow;
		logic rs485_en;
	} serial_cfg_t;
	typedef struct packed {
		logic [1:0] count;
		logic [7:0] resume_first;
		logic [7:0] resume_second;
		logic [7:0] pause_first;
		logic [7:0] pause_second;
	} flow_tx_t;
endpackage

// file: rtl/uart_feature_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Pin level read gives every pin's level; write sets output pins.
// - Enabled pins raise the pin interrupt on input change; disabled do not.
// - Upper four pin interrupt enables work only when modem select is 0.
// - Writing 1 to control bit 3 resets the UART, then the bit self-clears.
// - Control bit 1 makes upper pins general pins or RI, CD, DTR, DSR.
// - Unlatched: change raises interrupt; read or reverting pin clears it.
// - Latched: change captures value and interrupt until the level read.
// - Extra features bit 7 picks 3/16 or 1/4 infrared pulse width.
// - Polarity bit flips the RS-485 direction level, only while enabled.
// - Extra features bit 4 turns request-to-send into RS-485 direction.
// - Transmitter disable lets the current character finish, then stops.
// - Receiver disable stops reception; a character in progress completes.
// - Extra features bit 0 selects 8-bit or 9-bit multidrop mode.
// - Divisor is high and low bytes plus fraction nibble over sixteen.
// - Fraction register is reachable only while enhanced enable is 1.
// - Fraction bits 5:4 pick 16X, 8X or 4X oversampling.
// - Enhanced bits 3:2 pick transmit flow characters: none, first, second, both.
// - Enhanced bits 1:0 pick receive comparison, including either or sequential.
// - Dual mode treats both stored characters as one two-character code.
// - Enhanced bits change only while enhanced enable is 1; clearing it holds them.
// - Reset clears upper interrupt enables, FIFO and modem enhanced bits, fraction.
// - Divisor, scratch and flow characters default only at power-up.
// - Direction bit 0 makes the pin an input, 1 an output.
module uart_feature_regs (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ext_reset_n_i,
	input wire uart_ctl_pkg::reg_addr_t reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] gpio_in_i,
	output logic [7:0] gpio_out_o,
	output logic [7:0] gpio_oe_o,
	output logic gpio_irq_o,
	output logic modem_mode_o,
	output logic [2:0] modem_in_n_o,
	input wire logic tx_busy_i,
	input wire logic auto_rts_n_i,
	output logic rts_n_o,
	output uart_ctl_pkg::serial_cfg_t serial_cfg_o,
	output uart_ctl_pkg::flow_tx_t flow_tx_o,
	input wire logic [7:0] rx_char_i,
	input wire logic rx_char_valid_i,
	output logic rx_resume_o,
	output logic rx_pause_o,
	output logic [7:0] irq_enable_o,
	output logic [7:0] fifo_control_o,
	output logic [7:0] modem_control_o,
	output logic [7:0] flow_threshold_o,
	output logic [7:0] fifo_trigger_o,
	output logic uart_reset_o
);
	import uart_ctl_pkg::*;

	function automatic logic [7:0] merge_enh(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask, input logic enh);
		merge_enh = (new_v & ~mask) | ((enh ? new_v : old_v) & mask);
	endfunction

	logic [7:0] div_low_reg;
	logic [7:0] div_high_reg;
	logic [7:0] scratch_reg;
	logic [7:0] resume_first_reg;
	logic [7:0] resume_second_reg;
	logic [7:0] pause_first_reg;
	logic [7:0] pause_second_reg;
	logic [7:0] frac_reg;
	logic [7:0] ier_reg;
	logic [7:0] fcr_reg;
	logic [7:0] mcr_reg;
	logic [7:0] tcr_reg;
	logic [7:0] tlr_reg;
	logic [7:0] gpio_direction_reg;
	logic [7:0] gpio_pin_level_reg;
	logic [7:0] gpio_change_irq_enable_reg;
	logic [7:0] gpio_control_reg;
	logic soft_reset_reg;
	logic [7:0] extra_features_control_reg;
	logic [7:0] enhanced_feature_select_reg;
	logic [7:0] baseline_reg;
	logic [7:0] held_reg;
	logic [7:0] held_val_reg;
	logic base_valid_reg;
	logic [7:0] gpio_out_reg;
	logic [7:0] gpio_oe_reg;
	logic [2:0] modem_in_reg;
	logic irq_reg;
	logic rts_reg;
	logic urst_reg;
	logic [7:0] rdata_reg;
	logic rx_resume_reg;
	logic rx_pause_reg;
	match_state_t match_state_reg;
	match_state_t match_state_next;

	// Reset pin and software reset share one synchronous path.
	logic sync_rst;
	logic enh_on;
	assign sync_rst = !ext_reset_n_i || soft_reset_reg;
	assign enh_on = enhanced_feature_select_reg[EFR_ENH_BIT];

	logic wr_div_low, wr_div_high, wr_frac, wr_ier, wr_fcr, wr_mcr;
	logic wr_tcr, wr_tlr, wr_scratch, wr_dir, wr_level, wr_gpio_ie;
	logic wr_ctl, wr_extra_features_control, wr_efr, wr_res1, wr_res2, wr_pau1, wr_pau2;
	logic rd_level;
	assign wr_div_low = reg_wr_i && reg_addr_i == ADDR_DIVISOR_LOW;
	assign wr_div_high = reg_wr_i && reg_addr_i == ADDR_DIVISOR_HIGH;
	assign wr_frac = reg_wr_i && reg_addr_i == ADDR_DIVISOR_FRAC;
	assign wr_ier = reg_wr_i && reg_addr_i == ADDR_IRQ_ENABLE;
	assign wr_fcr = reg_wr_i && reg_addr_i == ADDR_FIFO_CONTROL;
	assign wr_mcr = reg_wr_i && reg_addr_i == ADDR_MODEM_CONTROL;
	assign wr_tcr = reg_wr_i && reg_addr_i == ADDR_FLOW_THRESHOLD;
	assign wr_tlr = reg_wr_i && reg_addr_i == ADDR_FIFO_TRIGGER;
	assign wr_scratch = reg_wr_i && reg_addr_i == ADDR_SCRATCH;
	assign wr_dir = reg_wr_i && reg_addr_i == ADDR_GPIO_DIRECTION;
	assign wr_level = reg_wr_i && reg_addr_i == ADDR_GPIO_LEVEL;
	assign wr_gpio_ie = reg_wr_i && reg_addr_i == ADDR_GPIO_IRQ_ENABLE;
	assign wr_ctl = reg_wr_i && reg_addr_i == ADDR_GPIO_CONTROL;
	assign wr_extra_features_control = reg_wr_i && reg_addr_i == ADDR_EXTRA_FEATURES;
	assign wr_efr = reg_wr_i && reg_addr_i == ADDR_ENHANCED_SELECT;
	assign wr_res1 = reg_wr_i && reg_addr_i == ADDR_RESUME_FIRST;
	assign wr_res2 = reg_wr_i && reg_addr_i == ADDR_RESUME_SECOND;
	assign wr_pau1 = reg_wr_i && reg_addr_i == ADDR_PAUSE_FIRST;
	assign wr_pau2 = reg_wr_i && reg_addr_i == ADDR_PAUSE_SECOND;
	assign rd_level = reg_rd_i && reg_addr_i == ADDR_GPIO_LEVEL;

	// Power-up-only group: neither the reset pin nor soft reset touches it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_low_reg <= RST_DIV_LOW;
			div_high_reg <= RST_DIV_HIGH;
			scratch_reg <= RST_SCRATCH;
			resume_first_reg <= RST_FLOW_CHAR;
			resume_second_reg <= RST_FLOW_CHAR;
			pause_first_reg <= RST_FLOW_CHAR;
			pause_second_reg <= RST_FLOW_CHAR;
		end else begin
			if (wr_div_low) div_low_reg <= reg_wdata_i;
			if (wr_div_high) div_high_reg <= reg_wdata_i;
			if (wr_scratch) scratch_reg <= reg_wdata_i;
			if (wr_res1) resume_first_reg <= reg_wdata_i;
			if (wr_res2) resume_second_reg <= reg_wdata_i;
			if (wr_pau1) pause_first_reg <= reg_wdata_i;
			if (wr_pau2) pause_second_reg <= reg_wdata_i;
		end
	end

	// Enhanced bits ignore writes while the enable is clear, so legacy
	// software cannot disturb them once they are set up.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frac_reg <= RST_ZERO;
			ier_reg <= RST_ZERO;
			fcr_reg <= RST_ZERO;
			mcr_reg <= RST_ZERO;
			tcr_reg <= RST_THRESHOLD;
			tlr_reg <= RST_ZERO;
		end else if (sync_rst) begin
			frac_reg <= RST_ZERO;
			ier_reg <= RST_ZERO;
			fcr_reg <= RST_ZERO;
			mcr_reg <= RST_ZERO;
			tcr_reg <= RST_THRESHOLD;
			tlr_reg <= RST_ZERO;
		end else begin
			if (wr_frac && enh_on)
				frac_reg <= reg_wdata_i & FRAC_RW_MASK;
			if (wr_ier)
				ier_reg <= merge_enh(ier_reg, reg_wdata_i,
					IER_ENH_MASK, enh_on);
			if (wr_fcr)
				fcr_reg <= merge_enh(fcr_reg, reg_wdata_i,
					FCR_ENH_MASK, enh_on);
			if (wr_mcr)
				mcr_reg <= merge_enh(mcr_reg, reg_wdata_i,
					MCR_ENH_MASK, enh_on);
			if (wr_tcr)
				tcr_reg <= merge_enh(tcr_reg, reg_wdata_i,
					ALL_ENH_MASK, enh_on);
			if (wr_tlr)
				tlr_reg <= merge_enh(tlr_reg, reg_wdata_i,
					ALL_ENH_MASK, enh_on);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_direction_reg <= RST_ZERO;
			gpio_pin_level_reg <= RST_ZERO;
			gpio_change_irq_enable_reg <= RST_ZERO;
			gpio_control_reg <= RST_ZERO;
			soft_reset_reg <= 1'b0;
			extra_features_control_reg <= RST_ZERO;
			enhanced_feature_select_reg <= RST_ZERO;
		end else if (sync_rst) begin
			gpio_direction_reg <= RST_ZERO;
			gpio_pin_level_reg <= RST_ZERO;
			gpio_change_irq_enable_reg <= RST_ZERO;
			gpio_control_reg <= RST_ZERO;
			soft_reset_reg <= 1'b0;
			extra_features_control_reg <= RST_ZERO;
			enhanced_feature_select_reg <= RST_ZERO;
		end else begin
			if (wr_dir) gpio_direction_reg <= reg_wdata_i;
			if (wr_level) gpio_pin_level_reg <= reg_wdata_i;
			if (wr_gpio_ie) gpio_change_irq_enable_reg <= reg_wdata_i;
			if (wr_ctl) begin
				gpio_control_reg <= reg_wdata_i & CTL_RW_MASK;
				soft_reset_reg <= reg_wdata_i[CTL_SOFT_RESET_BIT];
			end
			if (wr_extra_features_control)
				extra_features_control_reg <= reg_wdata_i & EXTRA_FEATURES_CONTROL_RW_MASK;
			if (wr_efr) enhanced_feature_select_reg <= reg_wdata_i;
		end
	end

	// Pin change tracking. The baseline is the value last reported to the
	// host, so a change that lands in the read cycle is seen afterwards.
	logic latch_on;
	logic modem_sel;
	logic [7:0] is_input;
	logic [7:0] changed;
	logic [7:0] held_mask;
	logic [7:0] level_view;
	logic [7:0] capture;
	logic [7:0] pending;
	logic [7:0] irq_en_eff;
	assign latch_on = gpio_control_reg[CTL_LATCH_BIT];
	assign modem_sel = gpio_control_reg[CTL_MODEM_SEL_BIT];
	assign is_input = ~gpio_direction_reg;
	assign changed = (gpio_in_i ^ baseline_reg) & is_input
		& {8{base_valid_reg}};
	assign held_mask = held_reg & {8{latch_on}};
	assign level_view = (gpio_in_i & ~held_mask)
		| (held_val_reg & held_mask);
	assign capture = changed & ~held_reg & {8{latch_on}};
	// Unlatched pending follows the pin, so a return to the old level drops it.
	assign pending = latch_on ? held_reg : changed;
	assign irq_en_eff = gpio_change_irq_enable_reg
		& {(modem_sel ? UPPER_OFF : UPPER_ON), UPPER_ON};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			baseline_reg <= RST_ZERO;
			held_reg <= RST_ZERO;
			held_val_reg <= RST_ZERO;
			base_valid_reg <= 1'b0;
		end else if (sync_rst) begin
			baseline_reg <= RST_ZERO;
			held_reg <= RST_ZERO;
			held_val_reg <= RST_ZERO;
			base_valid_reg <= 1'b0;
		end else if (!base_valid_reg || rd_level) begin
			baseline_reg <= level_view;
			held_reg <= RST_ZERO;
			base_valid_reg <= 1'b1;
		end else begin
			held_reg <= held_reg | capture;
			held_val_reg <= (held_val_reg & ~capture)
				| (gpio_in_i & capture);
		end
	end

	// Pin drive: outputs only where the direction says so; in modem mode the
	// DTR position drives from the modem control and the other upper pins are inputs.
	logic [7:0] out_next;
	logic [7:0] oe_next;
	logic dtr_n;
	assign dtr_n = ~mcr_reg[MCR_DTR_BIT];
	assign out_next = {gpio_pin_level_reg[7:6], modem_sel ? dtr_n
		: gpio_pin_level_reg[5], gpio_pin_level_reg[4:0]};
	assign oe_next = modem_sel ? {3'b001, 1'b0, gpio_direction_reg[3:0]}
		: gpio_direction_reg;

	// Direction output for RS-485 follows the transmitter's busy line.
	logic rts_next;
	logic rs485_on;
	assign rs485_on = extra_features_control_reg[EXTRA_FEATURES_CONTROL_RS485_EN_BIT];
	assign rts_next = rs485_on ? ~(tx_busy_i
		^ extra_features_control_reg[EXTRA_FEATURES_CONTROL_RS485_POL_BIT])
		: enhanced_feature_select_reg[EFR_AUTO_RTS_BIT] ? auto_rts_n_i
		: ~mcr_reg[MCR_RTS_BIT];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_out_reg <= RST_ZERO;
			gpio_oe_reg <= RST_ZERO;
			modem_in_reg <= MODEM_IDLE_N;
			irq_reg <= 1'b0;
			rts_reg <= 1'b1;
			urst_reg <= 1'b0;
		end else begin
			gpio_out_reg <= out_next;
			gpio_oe_reg <= oe_next;
			modem_in_reg <= modem_sel ? {gpio_in_i[7:6], gpio_in_i[4]}
				: MODEM_IDLE_N;
			irq_reg <= |(pending & irq_en_eff);
			rts_reg <= sync_rst ? 1'b1 : rts_next;
			urst_reg <= sync_rst;
		end
	end

	// Receive flow character comparison.
	logic [1:0] tx_sel;
	logic [1:0] rx_sel;
	logic rx_either;
	logic rx_seq;
	logic use_first;
	logic use_second;
	logic hit_r1, hit_r2, hit_p1, hit_p2;
	logic single_resume;
	logic single_pause;
	logic seq_resume;
	logic seq_pause;
	assign tx_sel = enhanced_feature_select_reg[3:2];
	assign rx_sel = enhanced_feature_select_reg[1:0];
	assign rx_either = rx_sel == FLOW_BOTH
		&& (tx_sel == FLOW_FIRST || tx_sel == FLOW_SECOND);
	assign rx_seq = rx_sel == FLOW_BOTH && !rx_either;
	assign use_first = rx_sel == FLOW_FIRST || rx_either;
	assign use_second = rx_sel == FLOW_SECOND || rx_either;
	assign hit_r1 = rx_char_i == resume_first_reg;
	assign hit_r2 = rx_char_i == resume_second_reg;
	assign hit_p1 = rx_char_i == pause_first_reg;
	assign hit_p2 = rx_char_i == pause_second_reg;
	assign single_resume = rx_char_valid_i
		&& ((use_first && hit_r1) || (use_second && hit_r2));
	assign single_pause = rx_char_valid_i
		&& ((use_first && hit_p1) || (use_second && hit_p2));
	assign seq_resume = rx_char_valid_i && rx_seq
		&& match_state_reg == MATCH_RESUME && hit_r2;
	assign seq_pause = rx_char_valid_i && rx_seq
		&& match_state_reg == MATCH_PAUSE && hit_p2;

	// A second character that breaks the pair is tried again as a first one.
	always_comb begin
		match_state_next = match_state_reg;
		if (!rx_seq) begin
			match_state_next = MATCH_IDLE;
		end else if (rx_char_valid_i) begin
			case (match_state_reg)
				MATCH_IDLE, MATCH_RESUME, MATCH_PAUSE: begin
					if (seq_resume || seq_pause)
						match_state_next = MATCH_IDLE;
					else if (hit_r1)
						match_state_next = MATCH_RESUME;
					else if (hit_p1)
						match_state_next = MATCH_PAUSE;
					else
						match_state_next = MATCH_IDLE;
				end
				default: match_state_next = MATCH_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_state_reg <= MATCH_IDLE;
			rx_resume_reg <= 1'b0;
			rx_pause_reg <= 1'b0;
		end else if (sync_rst) begin
			match_state_reg <= MATCH_IDLE;
			rx_resume_reg <= 1'b0;
			rx_pause_reg <= 1'b0;
		end else begin
			match_state_reg <= match_state_next;
			rx_resume_reg <= single_resume || seq_resume;
			rx_pause_reg <= single_pause || seq_pause;
		end
	end

	// Register read port; one cycle of latency, data held until next read.
	logic [7:0] read_value;
	logic [7:0] ctl_view;
	assign ctl_view = gpio_control_reg
		| ({7'h00, soft_reset_reg} << CTL_SOFT_RESET_BIT);
	always_comb begin
		read_value = RST_ZERO;
		case (reg_addr_i)
			ADDR_DIVISOR_LOW: read_value = div_low_reg;
			ADDR_DIVISOR_HIGH: read_value = div_high_reg;
			ADDR_DIVISOR_FRAC:
				read_value = enh_on ? frac_reg : RST_ZERO;
			ADDR_IRQ_ENABLE: read_value = ier_reg;
			ADDR_FIFO_CONTROL: read_value = fcr_reg;
			ADDR_MODEM_CONTROL: read_value = mcr_reg;
			ADDR_FLOW_THRESHOLD: read_value = tcr_reg;
			ADDR_FIFO_TRIGGER: read_value = tlr_reg;
			ADDR_SCRATCH: read_value = scratch_reg;
			ADDR_GPIO_DIRECTION: read_value = gpio_direction_reg;
			ADDR_GPIO_LEVEL: read_value = level_view;
			ADDR_GPIO_IRQ_ENABLE: read_value = gpio_change_irq_enable_reg;
			ADDR_GPIO_CONTROL: read_value = ctl_view;
			ADDR_EXTRA_FEATURES: read_value = extra_features_control_reg;
			ADDR_ENHANCED_SELECT: read_value = enhanced_feature_select_reg;
			ADDR_RESUME_FIRST: read_value = resume_first_reg;
			ADDR_RESUME_SECOND: read_value = resume_second_reg;
			ADDR_PAUSE_FIRST: read_value = pause_first_reg;
			ADDR_PAUSE_SECOND: read_value = pause_second_reg;
			default: read_value = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_reg <= RST_ZERO;
		else if (reg_rd_i)
			rdata_reg <= read_value;
	end

	oversample_t ovs;
	assign ovs = frac_reg[FRAC_4X_BIT] ? OVS_4X
		: frac_reg[FRAC_8X_BIT] ? OVS_8X : OVS_16X;

	assign serial_cfg_o.divisor = {div_high_reg, div_low_reg,
		frac_reg[3:0]};
	assign serial_cfg_o.oversample = ovs;
	assign serial_cfg_o.irda_fast =
		extra_features_control_reg[EXTRA_FEATURES_CONTROL_IRDA_BIT];
	assign serial_cfg_o.nine_bit =
		extra_features_control_reg[EXTRA_FEATURES_CONTROL_NINE_BIT];
	// The transmitter only samples this between characters.
	assign serial_cfg_o.tx_allow =
		~extra_features_control_reg[EXTRA_FEATURES_CONTROL_TX_DIS_BIT];
	// The receiver only samples this at a start bit.
	assign serial_cfg_o.rx_allow =
		~extra_features_control_reg[EXTRA_FEATURES_CONTROL_RX_DIS_BIT];
	assign serial_cfg_o.rs485_en = rs485_on;

	assign flow_tx_o.count = tx_sel == FLOW_NONE ? COUNT_NONE
		: tx_sel == FLOW_BOTH ? COUNT_TWO : COUNT_ONE;
	assign flow_tx_o.resume_first = tx_sel == FLOW_SECOND
		? resume_second_reg : resume_first_reg;
	assign flow_tx_o.resume_second = resume_second_reg;
	assign flow_tx_o.pause_first = tx_sel == FLOW_SECOND
		? pause_second_reg : pause_first_reg;
	assign flow_tx_o.pause_second = pause_second_reg;

	assign reg_rdata_o = rdata_reg;
	assign gpio_out_o = gpio_out_reg;
	assign gpio_oe_o = gpio_oe_reg;
	assign gpio_irq_o = irq_reg;
	assign modem_mode_o = modem_sel;
	assign modem_in_n_o = modem_in_reg;
	assign rts_n_o = rts_reg;
	assign rx_resume_o = rx_resume_reg;
	assign rx_pause_o = rx_pause_reg;
	assign irq_enable_o = ier_reg;
	assign fifo_control_o = fcr_reg;
	assign modem_control_o = mcr_reg;
	assign flow_threshold_o = tcr_reg;
	assign fifo_trigger_o = tlr_reg;
	assign uart_reset_o = urst_reg;
endmodule

// file: testbench/uart_feature_props.sv
`timescale 1ns/1ps
module uart_feature_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ext_reset_n_i,
	input wire uart_ctl_pkg::reg_addr_t reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] gpio_in_i,
	input wire logic [7:0] gpio_out_o,
	input wire logic [7:0] gpio_oe_o,
	input wire logic modem_mode_o,
	input wire logic [2:0] modem_in_n_o,
	input wire logic tx_busy_i,
	input wire logic rts_n_o,
	input wire uart_ctl_pkg::serial_cfg_t serial_cfg_o,
	input wire logic uart_reset_o
);
	import uart_ctl_pkg::*;
	wire w_ok = reg_wr_i && ext_reset_n_i;
	wire w_extra_features_control = w_ok && reg_addr_i == ADDR_EXTRA_FEATURES;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_kick;
		w_ok && reg_addr_i == ADDR_GPIO_CONTROL && reg_wdata_i[3];
	endsequence
	// The pin lags the transmitter by one cycle, so only settled spans count.
	sequence s_quiet;
		serial_cfg_o.rs485_en && !reg_wr_i && ext_reset_n_i && !uart_reset_o;
	endsequence
	AST_SRST: assert property (s_kick |-> ##[1:2] uart_reset_o)
		else $error("soft reset not issued");
	AST_OE: assert property (w_ok &&
		reg_addr_i == ADDR_GPIO_DIRECTION && !modem_mode_o
		|=> ##1 gpio_oe_o[3:0] == $past(reg_wdata_i[3:0], 2))
		else $error("direction not applied");
	AST_DRIVE: assert property (w_ok &&
		reg_addr_i == ADDR_GPIO_LEVEL |=> ##1
		((gpio_out_o ^ $past(reg_wdata_i, 2)) & gpio_oe_o & 8'h0F) == 8'h00)
		else $error("output level wrong");
	AST_NINE: assert property (w_extra_features_control |=>
		serial_cfg_o.nine_bit == $past(reg_wdata_i[EXTRA_FEATURES_CONTROL_NINE_BIT]))
		else $error("character mode wrong");
	AST_IRDA: assert property (w_extra_features_control |=>
		serial_cfg_o.irda_fast == $past(reg_wdata_i[EXTRA_FEATURES_CONTROL_IRDA_BIT]))
		else $error("infrared width wrong");
	AST_TXRX: assert property (w_extra_features_control |=>
		{serial_cfg_o.tx_allow, serial_cfg_o.rx_allow} == ~$past(reg_wdata_i[2:1]))
		else $error("disable bits wrong");
	AST_DIR: assert property (s_quiet[*2] |=>
		(rts_n_o ^ $past(tx_busy_i)) == ($past(rts_n_o) ^ $past(tx_busy_i, 2)))
		else $error("direction output not tracking");
	AST_MODEM: assert property (modem_mode_o |=> !modem_mode_o ||
		modem_in_n_o == {$past(gpio_in_i[7:6]), $past(gpio_in_i[4])})
		else $error("modem inputs wrong");
endmodule
bind uart_feature_regs uart_feature_props u_props (.clk_i, .rst_n_i,
	.ext_reset_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .gpio_in_i,
	.gpio_out_o, .gpio_oe_o, .modem_mode_o, .modem_in_n_o, .tx_busy_i,
	.rts_n_o, .serial_cfg_o, .uart_reset_o);

// file: testbench/gpio_pad_model.sv
`timescale 1ns/1ps
module gpio_pad_model (
	input wire logic [7:0] drive_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] far_i,
	output logic [7:0] pad_o
);
	assign pad_o = (drive_i & oe_i) | (far_i & ~oe_i);
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import uart_ctl_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	reg_addr_t addr = ADDR_SCRATCH;
	logic wr = 1'b0, rd = 1'b0, busy = 1'b0, ext_n = 1'b1;
	logic [7:0] wd = 8'h00, far = 8'h5A, rdata, pad, gout, goe;
	logic [7:0] rx_c = 8'h00;
	logic irq, mode, rts_n, ures, rx_res, rx_pau, rx_v = 1'b0;
	serial_cfg_t cfg;
	flow_tx_t flow;
	oversample_t osv [4] = '{OVS_16X, OVS_8X, OVS_4X, OVS_4X};
	int n_errors = 0, cmp_count = 0;
	gpio_pad_model u_gpio_pad_model (.drive_i(gout), .oe_i(goe), .far_i(far),
		.pad_o(pad));
	uart_feature_regs u_uart_feature_regs (.clk_i, .rst_n_i,
		.ext_reset_n_i(ext_n), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
		.gpio_in_i(pad), .gpio_out_o(gout), .gpio_oe_o(goe),
		.gpio_irq_o(irq), .modem_mode_o(mode), .modem_in_n_o(),
		.tx_busy_i(busy), .auto_rts_n_i(1'b1), .rts_n_o(rts_n),
		.serial_cfg_o(cfg), .flow_tx_o(flow), .rx_char_i(rx_c),
		.rx_char_valid_i(rx_v), .rx_resume_o(rx_res), .rx_pause_o(rx_pau),
		.irq_enable_o(), .fifo_control_o(), .modem_control_o(),
		.flow_threshold_o(), .fifo_trigger_o(), .uart_reset_o(ures));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic wreg(input reg_addr_t a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rchk(input reg_addr_t a, input logic [7:0] e);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// The match flags pulse for one cycle, so they are looked at right away.
	task automatic rxc(input logic [7:0] c, input logic [1:0] e);
		@(posedge clk_i);
		rx_c <= c;
		rx_v <= 1'b1;
		@(posedge clk_i);
		rx_v <= 1'b0;
		#1 chk({6'h00, rx_res, rx_pau}, {6'h00, e});
	endtask
	// Two edges let a pin change pass the baseline compare and the flop.
	task automatic stim(input logic [7:0] p, input logic b);
		@(posedge clk_i);
		far <= p;
		busy <= b;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk(ADDR_DIVISOR_LOW, RST_DIV_LOW);
		rchk(ADDR_FLOW_THRESHOLD, RST_THRESHOLD);
		wreg(ADDR_IRQ_ENABLE, 8'hFF);
		rchk(ADDR_IRQ_ENABLE, 8'h0F);
		wreg(ADDR_DIVISOR_FRAC, 8'h3F);
		rchk(ADDR_DIVISOR_FRAC, 8'h00);
		wreg(ADDR_ENHANCED_SELECT, 8'h10);
		for (int i = 0; i < 4; i++) begin
			wreg(ADDR_DIVISOR_FRAC, {2'b00, i[1:0], 4'hA});
			chk(cfg.oversample, osv[i]);
		end
		chk(cfg.divisor[11:4], 8'h01);
		wreg(ADDR_ENHANCED_SELECT, 8'h00);
		wreg(ADDR_DIVISOR_FRAC, 8'h00);
		chk(cfg.oversample, OVS_4X);
		wreg(ADDR_GPIO_DIRECTION, 8'h0F);
		wreg(ADDR_GPIO_LEVEL, 8'hC3);
		rchk(ADDR_GPIO_LEVEL, 8'h53);
		wreg(ADDR_GPIO_IRQ_ENABLE, 8'h10);
		stim(8'h7A, 1'b0);
		chk(irq, 1'b0);
		stim(8'h6A, 1'b0);
		chk(irq, 1'b1);
		stim(8'h7A, 1'b0);
		chk(irq, 1'b0);
		stim(8'h6A, 1'b0);
		rchk(ADDR_GPIO_LEVEL, 8'h63);
		stim(8'h6A, 1'b0);
		chk(irq, 1'b0);
		wreg(ADDR_GPIO_CONTROL, 8'h01);
		stim(8'h7A, 1'b0);
		stim(8'h6A, 1'b0);
		chk(irq, 1'b1);
		rchk(ADDR_GPIO_LEVEL, 8'h73);
		wreg(ADDR_GPIO_CONTROL, 8'h02);
		rchk(ADDR_GPIO_CONTROL, 8'h02);
		wreg(ADDR_GPIO_IRQ_ENABLE, 8'hF0);
		stim(8'hEA, 1'b0);
		chk(irq, 1'b0);
		wreg(ADDR_SCRATCH, 8'h3C);
		wreg(ADDR_GPIO_CONTROL, 8'h08);
		repeat (4) @(posedge clk_i);
		rchk(ADDR_SCRATCH, 8'h3C);
		rchk(ADDR_GPIO_CONTROL, 8'h00);
		chk(goe, 8'h00);
		wreg(ADDR_EXTRA_FEATURES, 8'h10);
		stim(far, 1'b1);
		chk(rts_n, 1'b0);
		wreg(ADDR_EXTRA_FEATURES, 8'hB7);
		stim(far, 1'b0);
		chk(rts_n, 1'b0);
		chk({cfg.irda_fast, cfg.nine_bit, cfg.tx_allow, cfg.rx_allow},
			8'h0C);
		wreg(ADDR_ENHANCED_SELECT, 8'h1C);
		chk(flow.count, COUNT_TWO);
		wreg(ADDR_ENHANCED_SELECT, 8'h10);
		wreg(ADDR_ENHANCED_SELECT, 8'h1A);
		chk(flow.count, COUNT_ONE);
		wreg(ADDR_RESUME_FIRST, 8'h11);
		rxc(8'h11, 2'b10);
		wreg(ADDR_ENHANCED_SELECT, 8'h10);
		wreg(ADDR_ENHANCED_SELECT, 8'h1F);
		rxc(8'h11, 2'b00);
		rxc(8'h00, 2'b10);
		// A pulse on the reset pin must spare the power-up-only group.
		@(posedge clk_i);
		ext_n <= 1'b0;
		@(posedge clk_i);
		ext_n <= 1'b1;
		rchk(ADDR_SCRATCH, 8'h3C);
		rchk(ADDR_RESUME_FIRST, 8'h11);
		chk(rts_n, 1'b1);
		conclude();
	end
	initial begin
		// The sequence needs well under a thousand cycles.
		#100000;
		n_errors++;
		conclude();
	end
endmodule
